//--- cmbim_pkg.sv
package cmbim_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int NTX = 3;
	localparam int IDX_W = 2;
	localparam int NBYTE = 4;
	localparam int KEY_W = 32;

	////////////////////////////////////////////////////////////////////////////////
	// register map: addr[7:4] picks a window, addr[3:0] the byte inside it
	localparam logic [3:0] RX_WIN = 4'h0;
	localparam logic [3:0] TX_WIN = 4'h1;
	localparam logic [7:0] SEL_ADDR = 8'h20;
	localparam logic [7:0] STAT_ADDR = 8'h21;
	localparam logic [3:0] OFS_ID0 = 4'h0;
	localparam logic [3:0] OFS_ID1 = 4'h1;
	localparam logic [3:0] OFS_ID2 = 4'h2;
	localparam logic [3:0] OFS_ID3 = 4'h3;
	localparam logic [3:0] OFS_LEN = 4'hC;

	////////////////////////////////////////////////////////////////////////////////
	// reset values and field figures
	localparam logic [NTX-1:0] SEL_RST = 3'h0;
	localparam logic [7:0] RD_IDLE = 8'h00;
	localparam logic [3:0] MAX_BYTES = 4'h8;
	localparam logic [3:0] NO_BYTES = 4'h0;
	localparam logic [5:0] EXT_BITS = 6'h20;
	localparam logic [5:0] STD_BITS = 6'h0D;
	localparam logic [5:0] NO_BITS = 6'h00;

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [28:0] frame_identifier;
		logic        srr;
		logic        ide;
		logic        rtr;
		logic [3:0]  dlc;
	} cmbim_frame_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cmbim_cpu_req_t;

endpackage

//--- cmbim_top.sv
// What this block does
// RQ1: tx ident reads need empty flag and select
// RQ2: tx ident writes need empty flag and select
// RQ3: rx ident reads only while rx full
// RQ4: no cpu write path into rx identifiers
// RQ5: identifier storage has no reset value
// RQ6: extended format carries 32 identifier bits
// RQ7: standard format carries 13 meaningful bits
// RQ8: extended byte 0 holds id 28..21
// RQ9: extended byte 1 id 20..18, srr, ide, 17..15
// RQ10: extended byte 2 holds id 14..7
// RQ11: extended byte 3 id 6..0, rtr
// RQ12: standard bytes 0,1 hold id, rtr, ide
// RQ13: msb sent first, smaller id wins
// RQ14: software sets srr in extended tx buffers
// RQ15: rx srr stored exactly as sampled
// RQ16: ide picks 11 or 29 bit format
// RQ17: extended has srr, ide set; standard ide 0
// RQ18: rtr zero data frame, one remote
// RQ19: rtr at byte3 bit0 or byte1 bit4
// RQ20: length gives 0..8 bytes, remote sends none
// RQ21: gated writes ignored, gated reads unspecified
`timescale 1ns/1ps
`default_nettype none

module cmbim_top (
	input  wire logic                     ref_clk,
	input  wire logic                     reset_n,
	input  wire cmbim_pkg::cmbim_cpu_req_t cpu_req,
	output var  logic [7:0]               rd_data,
	input  wire logic [cmbim_pkg::NTX-1:0] tx_buffer_empty_flag,
	input  wire logic                     rx_buffer_full_flag,
	input  wire logic                     rx_store,
	input  wire cmbim_pkg::cmbim_frame_t  rx_frame,
	input  wire logic                     tx_load,
	input  wire logic                     tx_shift,
	output var  logic                     tx_bit,
	output var  logic                     tx_active,
	output var  logic                     tx_win_valid,
	output var  logic [cmbim_pkg::IDX_W-1:0] tx_win_idx,
	output var  cmbim_pkg::cmbim_frame_t  tx_frame,
	output var  logic [3:0]               tx_data_bytes
);
	import cmbim_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// functions
	function automatic logic [31:0] id_pack(input cmbim_frame_t f);
		logic [31:0] b;
		b = '0;
		if (f.ide) begin
			b[31:24] = f.frame_identifier[28:21];                                   // RQ8
			b[23:16] = {f.frame_identifier[20:18], f.srr, f.ide,
				f.frame_identifier[17:15]};                                         // RQ9
			b[15:8] = f.frame_identifier[14:7];                                     // RQ10
			b[7:0] = {f.frame_identifier[6:0], f.rtr};                              // RQ11 RQ19 RQ6
		end else begin
			b[31:24] = f.frame_identifier[10:3];                                    // RQ12
			b[23:16] = {f.frame_identifier[2:0], f.rtr, f.ide, 3'h0};               // RQ12 RQ19 RQ7
		end
		return b;
	endfunction

	function automatic cmbim_frame_t id_unpack(input logic [31:0] b, input logic [3:0] len);
		cmbim_frame_t f;
		f = '0;
		f.dlc = len;
		f.ide = b[19];                                                              // RQ16
		if (f.ide) begin
			f.frame_identifier = {b[31:24], b[23:21], b[18:16], b[15:8], b[7:1]};
			f.srr = b[20];                                                          // RQ17
			f.rtr = b[0];                                                           // RQ19
		end else begin
			f.frame_identifier = {18'h00000, b[31:24], b[23:21]};
			f.srr = 1'b0;
			f.rtr = b[20];                                                          // RQ19
		end
		return f;
	endfunction

	// arbitration field in bus order, msb first; standard frames pad low
	function automatic logic [KEY_W-1:0] arb_key(input cmbim_frame_t f);
		if (f.ide)
			return {f.frame_identifier[28:18], f.srr, f.ide, f.frame_identifier[17:0], f.rtr};
		return {f.frame_identifier[10:0], f.rtr, f.ide, 19'h00000};                 // RQ13
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// storage: tx buffers 0..NTX-1, rx buffer at NTX; no reset on purpose
	logic [7:0]  id_mem  [NTX+1][NBYTE];                                            // RQ5
	logic [3:0]  len_mem [NTX+1];
	logic [NTX-1:0] sel_r;
	logic        rx_loaded_r;

	////////////////////////////////////////////////////////////////////////////////
	// access gating
	logic [3:0]       win;
	logic [3:0]       ofs;
	logic [NTX-1:0]   tx_open;
	logic [IDX_W-1:0] tx_idx;
	logic             tx_ok;

	assign win = cpu_req.addr[7:4];
	assign ofs = cpu_req.addr[3:0];
	assign tx_open = sel_r & tx_buffer_empty_flag;

	always_comb begin
		tx_idx = '0;
		tx_ok = 1'b0;
		for (int i = NTX - 1; i >= 0; i--) begin
			if (tx_open[i]) begin
				tx_idx = IDX_W'(i);
				tx_ok = 1'b1;                                                       // RQ1 RQ2
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// select register
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			sel_r <= SEL_RST;
		else if (cpu_req.wr && cpu_req.addr == SEL_ADDR)
			sel_r <= cpu_req.wdata[NTX-1:0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// buffer writes: cpu into the selected tx buffer, controller into rx
	always_ff @(posedge ref_clk) begin
		if (cpu_req.wr && win == TX_WIN && tx_ok) begin                             // RQ2 RQ21
			if (ofs <= OFS_ID3)
				id_mem[tx_idx][ofs[1:0]] <= cpu_req.wdata;
			else if (ofs == OFS_LEN)
				len_mem[tx_idx] <= cpu_req.wdata[3:0];
		end
		if (rx_store) begin                                                         // RQ4 RQ15 RQ16
			{id_mem[NTX][0], id_mem[NTX][1], id_mem[NTX][2], id_mem[NTX][3]} <=
				id_pack(rx_frame);
			len_mem[NTX] <= rx_frame.dlc;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			rx_loaded_r <= 1'b0;
		else if (rx_store)
			rx_loaded_r <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// read port: data only in the cycle after the strobe
	logic [7:0] rd_data_nxt;

	always_comb begin
		rd_data_nxt = RD_IDLE;
		if (cpu_req.rd) begin
			if (win == RX_WIN && rx_buffer_full_flag) begin                         // RQ3
				if (ofs <= OFS_ID3)
					rd_data_nxt = id_mem[NTX][ofs[1:0]];
				else if (ofs == OFS_LEN)
					rd_data_nxt = {4'h0, len_mem[NTX]};
			end else if (win == TX_WIN && tx_ok) begin                              // RQ1 RQ21
				if (ofs <= OFS_ID3)
					rd_data_nxt = id_mem[tx_idx][ofs[1:0]];
				else if (ofs == OFS_LEN)
					rd_data_nxt = {4'h0, len_mem[tx_idx]};
			end else if (cpu_req.addr == SEL_ADDR) begin
				rd_data_nxt = {5'h00, sel_r};
			end else if (cpu_req.addr == STAT_ADDR) begin
				rd_data_nxt = {tx_win_valid, tx_active, tx_win_idx, 1'b0, tx_ok,
					rx_buffer_full_flag, rx_loaded_r};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			rd_data <= RD_IDLE;
		else
			rd_data <= rd_data_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// internal prioritisation: smallest arbitration key, then lower index
	logic             win_valid_nxt;
	logic [IDX_W-1:0] win_idx_nxt;
	logic [KEY_W-1:0] win_key_nxt;
	cmbim_frame_t     win_frame_nxt;
	logic [KEY_W-1:0] win_key_r;

	always_comb begin
		cmbim_frame_t f;
		f = '0;
		win_valid_nxt = 1'b0;
		win_idx_nxt = '0;
		win_key_nxt = '0;
		win_frame_nxt = '0;
		for (int i = 0; i < NTX; i++) begin
			f = id_unpack({id_mem[i][0], id_mem[i][1], id_mem[i][2], id_mem[i][3]},
				len_mem[i]);
			if (!tx_buffer_empty_flag[i] &&
				(!win_valid_nxt || arb_key(f) < win_key_nxt)) begin                 // RQ13
				win_valid_nxt = 1'b1;
				win_idx_nxt = IDX_W'(i);
				win_key_nxt = arb_key(f);
				win_frame_nxt = f;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			tx_win_valid <= 1'b0;
			tx_win_idx <= '0;
			tx_frame <= '0;
			win_key_r <= '0;
			tx_data_bytes <= NO_BYTES;
		end else begin
			tx_win_valid <= win_valid_nxt;
			tx_win_idx <= win_idx_nxt;
			tx_frame <= win_frame_nxt;
			win_key_r <= win_key_nxt;
			if (!win_valid_nxt || win_frame_nxt.rtr)                                // RQ18 RQ20
				tx_data_bytes <= NO_BYTES;
			else if (win_frame_nxt.dlc > MAX_BYTES)
				tx_data_bytes <= MAX_BYTES;
			else
				tx_data_bytes <= win_frame_nxt.dlc;                                 // RQ20
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// arbitration field shifter, msb first
	logic [KEY_W-1:0] sr_r;
	logic [5:0]       cnt_r;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sr_r <= '0;
			cnt_r <= NO_BITS;
			tx_active <= 1'b0;
		end else if (tx_load && tx_win_valid) begin
			sr_r <= win_key_r;                                                      // RQ13
			cnt_r <= tx_frame.ide ? EXT_BITS : STD_BITS;                            // RQ16
			tx_active <= 1'b1;
		end else if (tx_shift && cnt_r != NO_BITS) begin
			sr_r <= {sr_r[KEY_W-2:0], 1'b0};                                        // RQ13
			cnt_r <= cnt_r - 6'h01;
			tx_active <= (cnt_r != 6'h01);
		end
	end

	assign tx_bit = sr_r[KEY_W-1];

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	sequence s_tx_write_id0;
		cpu_req.wr && win == TX_WIN && tx_ok && ofs == OFS_ID0;
	endsequence

	sequence s_tx_read_back;
		cpu_req.rd && win == TX_WIN && tx_ok && ofs == OFS_ID0 &&
			tx_idx == $past(tx_idx) && !cpu_req.wr;
	endsequence

	a_tx_read_gate: assert property (                                              // RQ1
		cpu_req.rd && win == TX_WIN && !tx_ok |=> rd_data == RD_IDLE)
		else $error("tx ident read passed while closed");

	a_tx_write_back: assert property (                                             // RQ2
		s_tx_write_id0 ##1 s_tx_read_back |=> rd_data == $past(cpu_req.wdata, 2))
		else $error("tx ident write not read back");

	a_rx_read_gate: assert property (                                              // RQ3
		cpu_req.rd && win == RX_WIN && !rx_buffer_full_flag |=> rd_data == RD_IDLE)
		else $error("rx ident read passed while not full");

	a_rx_no_cpu_write: assert property (                                           // RQ4
		rx_loaded_r && cpu_req.wr && win == RX_WIN && !rx_store |=>
			$stable(id_mem[NTX][0]) && $stable(id_mem[NTX][3]))
		else $error("cpu write changed rx identifier");

	a_ext_map_bytes: assert property (                                             // RQ8
		rx_store && rx_frame.ide |=>
			id_mem[NTX][0] == $past(rx_frame.frame_identifier[28:21]) &&
			id_mem[NTX][2] == $past(rx_frame.frame_identifier[14:7]))
		else $error("extended byte mapping wrong");

	a_ext_srr_ide: assert property (                                               // RQ15
		rx_store && rx_frame.ide |=>
			id_mem[NTX][1][4] == $past(rx_frame.srr) && id_mem[NTX][1][3])
		else $error("rx srr or ide not stored as sampled");

	a_rtr_position: assert property (                                              // RQ19
		rx_store |=> ($past(rx_frame.ide) ? id_mem[NTX][3][0] : id_mem[NTX][1][4]) ==
			$past(rx_frame.rtr))
		else $error("rtr in wrong position");

	a_std_map_bytes: assert property (                                             // RQ12
		rx_store && !rx_frame.ide |=>
			id_mem[NTX][0] == $past(rx_frame.frame_identifier[10:3]) &&
			id_mem[NTX][1][7:5] == $past(rx_frame.frame_identifier[2:0]))
		else $error("standard byte mapping wrong");

	a_msb_first: assert property (                                                 // RQ13
		tx_load && tx_win_valid ##1 tx_shift && !tx_load |=>
			tx_bit == $past(win_key_r[KEY_W-2], 2))
		else $error("arbitration bits not msb first");

	a_remote_no_data: assert property (                                            // RQ20
		tx_win_valid && tx_frame.rtr |-> tx_data_bytes == NO_BYTES)
		else $error("remote frame given data bytes");

	a_frame_bits: assert property (                                                // RQ16
		tx_load && tx_win_valid |=> cnt_r == ($past(tx_frame.ide) ? EXT_BITS : STD_BITS))
		else $error("arbitration length wrong for format");

	a_ext_byte1_map: assert property (                                             // RQ9
		rx_store && rx_frame.ide |=>
			id_mem[NTX][1][7:5] == $past(rx_frame.frame_identifier[20:18]) &&
			id_mem[NTX][1][2:0] == $past(rx_frame.frame_identifier[17:15]))
		else $error("extended byte 1 mapping wrong");

	a_ext_byte3_map: assert property (                                             // RQ11
		rx_store && rx_frame.ide |=>
			id_mem[NTX][3][7:1] == $past(rx_frame.frame_identifier[6:0]))
		else $error("extended byte 3 mapping wrong");

	a_rx_read_data: assert property (                                              // RQ3
		cpu_req.rd && win == RX_WIN && rx_buffer_full_flag && ofs == OFS_ID2 |=>
			rd_data == $past(id_mem[NTX][2]))
		else $error("rx ident read returned wrong byte");

	a_std_ide_clear: assert property (                                             // RQ17
		rx_store && !rx_frame.ide |=> !id_mem[NTX][1][3])
		else $error("standard frame stored with ide set");

	a_rx_len_store: assert property (                                              // RQ20
		rx_store |=> len_mem[NTX] == $past(rx_frame.dlc))
		else $error("rx length not stored");

	a_tx_write_gate: assert property (                                             // RQ21
		cpu_req.wr && win == TX_WIN && !tx_ok && ofs == OFS_ID0 |=> $stable(id_mem[0][0]))
		else $error("closed tx write changed storage");

	a_data_frame_len: assert property (                                            // RQ20
		tx_win_valid && !tx_frame.rtr && tx_frame.dlc <= MAX_BYTES |->
			tx_data_bytes == tx_frame.dlc)
		else $error("data frame byte count wrong");

	a_shift_count: assert property (                                               // RQ6
		tx_shift && tx_active && !tx_load |=> cnt_r == $past(cnt_r) - 6'h01)
		else $error("shift did not consume one bit");

	a_sel_write: assert property (                                                 // RQ1
		cpu_req.wr && cpu_req.addr == SEL_ADDR |=> sel_r == $past(cpu_req.wdata[NTX-1:0]))
		else $error("select register not written");

	a_read_one_cycle: assert property (                                            // RQ21
		!cpu_req.rd |=> rd_data == RD_IDLE)
		else $error("read data held past its cycle");

	a_load_msb: assert property (                                                  // RQ13
		tx_load && tx_win_valid |=> tx_active && tx_bit == $past(win_key_r[KEY_W-1]))
		else $error("load did not present first arbitration bit");

endmodule

`default_nettype wire

//--- cmbim_spare.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- cmbim_can_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// far side: receiver feeding frames, transmitter pulling arbitration bits
module cmbim_can_model (
	input  wire logic                    ref_clk,
	input  wire logic                    tx_bit,
	input  wire logic                    tx_active,
	output var  logic                    rx_store,
	output var  cmbim_pkg::cmbim_frame_t rx_frame,
	output var  logic                    tx_load,
	output var  logic                    tx_shift
);
	import cmbim_pkg::*;

	initial begin
		rx_store = 1'b0;
		rx_frame = '0;
		tx_load = 1'b0;
		tx_shift = 1'b0;
	end

	// released receive lines show the inverse of the last frame
	task automatic send(input cmbim_frame_t f);
		@(posedge ref_clk);
		rx_store <= 1'b1;
		rx_frame <= f;
		@(posedge ref_clk);
		rx_store <= 1'b0;
		rx_frame <= ~f;
	endtask

	// load the winner, then shift every cycle until the shifter runs dry
	task automatic collect(output logic [31:0] key, output int n);
		key = '0;
		n = 0;
		@(posedge ref_clk);
		tx_load <= 1'b1;
		@(posedge ref_clk);
		tx_load <= 1'b0;
		tx_shift <= 1'b1;
		repeat (40) begin
			@(negedge ref_clk);
			if (tx_active !== 1'b1) break;
			key = {key[30:0], tx_bit};
			n++;
		end
		@(posedge ref_clk);
		tx_shift <= 1'b0;
	endtask
endmodule

`default_nettype wire

//--- tb_can_msg_buffer_identifier_map.sv
`timescale 1ns/1ps
`default_nettype none

module tb_can_msg_buffer_identifier_map;
	import cmbim_pkg::*;

	logic           ref_clk;
	logic           reset_n;
	cmbim_cpu_req_t cpu_req;
	logic [7:0]     rd_data;
	logic [NTX-1:0] empty;
	logic           rx_full;
	logic           rx_store;
	cmbim_frame_t   rx_frame;
	logic           tx_load;
	logic           tx_shift;
	logic           tx_bit;
	logic           tx_active;
	logic           tx_win_valid;
	logic [IDX_W-1:0] tx_win_idx;
	cmbim_frame_t   tx_frame;
	logic [3:0]     tx_data_bytes;
	int             bad_count;
	int             tests_run;
	logic [31:0]    k;
	int             n;
	cmbim_frame_t   fa;
	cmbim_frame_t   fb;
	cmbim_frame_t   fr;

	cmbim_top u_cmbim_top (.ref_clk(ref_clk), .reset_n(reset_n), .cpu_req(cpu_req),
		.rd_data(rd_data), .tx_buffer_empty_flag(empty), .rx_buffer_full_flag(rx_full),
		.rx_store(rx_store), .rx_frame(rx_frame), .tx_load(tx_load), .tx_shift(tx_shift),
		.tx_bit(tx_bit), .tx_active(tx_active), .tx_win_valid(tx_win_valid),
		.tx_win_idx(tx_win_idx), .tx_frame(tx_frame), .tx_data_bytes(tx_data_bytes));

	cmbim_can_model u_cmbim_can_model (.ref_clk(ref_clk), .tx_bit(tx_bit),
		.tx_active(tx_active), .rx_store(rx_store), .rx_frame(rx_frame),
		.tx_load(tx_load), .tx_shift(tx_shift));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	task automatic close_out();
		$display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// arbitration bits in bus order; standard keys fill the low 13 bits
	function automatic logic [31:0] key_of(input cmbim_frame_t f);
		if (f.ide)
			return {f.frame_identifier[28:18], f.srr, f.ide, f.frame_identifier[17:0], f.rtr};
		return {19'h0, f.frame_identifier[10:0], f.rtr, f.ide};
	endfunction

	// the four identifier bytes, byte 0 on top
	function automatic logic [31:0] img(input cmbim_frame_t f);
		logic [31:0] kk;
		kk = key_of(f);
		return f.ide ? kk : {kk[12:0], 19'h0};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		cpu_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		cpu_req <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		cpu_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		cpu_req <= '0;
		@(negedge ref_clk);
		check(rd_data, e);
	endtask

	// write then read back the same byte with no gap between the strobes
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		cpu_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		cpu_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		cpu_req <= '0;
		@(negedge ref_clk);
		check(rd_data, d);
	endtask

	task automatic wr_buf(input cmbim_frame_t f);
		logic [31:0] b;
		b = img(f);
		for (int i = 0; i < NBYTE; i++) wr({TX_WIN, 4'(i)}, b[31-8*i -: 8]);
		wr({TX_WIN, OFS_LEN}, {4'h0, f.dlc});
	endtask

	task automatic rd_buf(input logic [3:0] win, input cmbim_frame_t f, input int nb);
		logic [31:0] b;
		b = img(f);
		for (int i = 0; i < nb; i++) rd({win, 4'(i)}, b[31-8*i -: 8]);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_tx_regs();
		wr(SEL_ADDR, 8'h01);
		wr_buf(fa);
		rd_buf(TX_WIN, fa, 4);
		rd({TX_WIN, OFS_LEN}, {4'h0, fa.dlc});
		wr(SEL_ADDR, 8'h00);
		rd({TX_WIN, OFS_ID0}, 8'h00);
		wr({TX_WIN, OFS_ID0}, 8'hFF);
		wr(SEL_ADDR, 8'h01);
		rd_buf(TX_WIN, fa, 1);
		k = img(fa);
		wr_rd({TX_WIN, OFS_ID0}, k[31:24]);
	endtask

	task automatic t_rx();
		cmbim_frame_t fs;
		fs = '{frame_identifier: 29'h555, srr: 1'b0, ide: 1'b0, rtr: 1'b1, dlc: 4'h2};
		u_cmbim_can_model.send(fr);
		rd({RX_WIN, OFS_ID0}, 8'h00);
		@(posedge ref_clk);
		rx_full <= 1'b1;
		rd_buf(RX_WIN, fr, 4);
		wr({RX_WIN, OFS_ID3}, 8'h00);
		k = img(fr);
		rd({RX_WIN, OFS_ID3}, k[7:0]);
		u_cmbim_can_model.send(fs);
		rd_buf(RX_WIN, fs, 4);
		rd({RX_WIN, OFS_LEN}, {4'h0, fs.dlc});
		@(posedge ref_clk);
		rx_full <= 1'b0;
	endtask

	task automatic t_arb();
		wr(SEL_ADDR, 8'h02);
		wr_buf(fb);
		@(posedge ref_clk);
		empty <= 3'b100;
		repeat (3) @(negedge ref_clk);
		check({tx_win_valid, tx_win_idx}, 3'h4);
		check(tx_data_bytes, fa.dlc);
		check({tx_frame.srr, tx_frame.ide}, 2'b11);
		check(tx_frame.frame_identifier, fa.frame_identifier);
		u_cmbim_can_model.collect(k, n);
		check(n, 32);
		check(k, key_of(fa));
		@(posedge ref_clk);
		empty <= 3'b101;
		repeat (3) @(negedge ref_clk);
		check({tx_win_valid, tx_win_idx}, 3'h5);
		check(tx_data_bytes, NO_BYTES);
		check({tx_frame.ide, tx_frame.rtr}, 2'b01);
		u_cmbim_can_model.collect(k, n);
		check(n, 13);
		check(k, key_of(fb));
		@(posedge ref_clk);
		empty <= 3'b111;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence and watchdog
	initial begin
		bad_count = 0;
		tests_run = 0;
		reset_n = 1'b0;
		cpu_req = '0;
		empty = 3'b111;
		rx_full = 1'b0;
		fa = '{frame_identifier: 29'h0ABCDEF1, srr: 1'b1, ide: 1'b1, rtr: 1'b0, dlc: 4'h5};
		fb = '{frame_identifier: 29'h7FF, srr: 1'b0, ide: 1'b0, rtr: 1'b1, dlc: MAX_BYTES};
		fr = '{frame_identifier: 29'h12345678, srr: 1'b0, ide: 1'b1, rtr: 1'b1, dlc: 4'h3};
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(negedge ref_clk);
		check({rd_data, tx_win_valid, tx_active}, 32'h0);
		t_tx_regs();
		t_rx();
		t_arb();
		close_out();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		close_out();
	end
endmodule

`default_nettype wire
